// file: inc/scf_pkg.sv
/*
 Constants of the sinc-cubed decimation filter and its conversion timing:
 register map, field positions, reset values and per-rate timing tables.
 Assumes a consumer that refers to every name as scf_pkg::name.
*/
// Behaviour
// - filter bit clear selects sinc-cubed path
// - three cycles settle; first two sinc-cubed results suppressed
// - sinc-cubed response from three integrators, three combs
// - decimation equals data period; nulls at rate
// - all timing counted in ADC clock ticks
// - start on trigger rising edge or command
// - programmable delay, default fourteen modulator periods
// - first result: delay, sampling, overhead; later periodic
// - later continuous results skip the delay
// - overhead time precedes every delivered result
// - suppressed results get no overhead time
// - first result timing from per-rate table
// - later results spaced one data period
// - same sequence for both filters; third delivered on sinc-cubed, first on the other
`default_nettype none
package scf_pkg;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 19;
   localparam int ACC_W = 52;
   localparam int RATE_N = 14;
   localparam logic [7:0] REG_DATARATE = 8'h04;
   localparam logic [7:0] REG_DELAY = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RESULT = 8'h10;
   localparam int DR_RATE_LSB = 0;
   localparam int DR_FILTER_BIT = 4;
   localparam int DR_SINGLE_BIT = 5;
   localparam logic [7:0] DATARATE_RST = 8'h0D;
   localparam logic [2:0] DELAY_RST = 3'h0;
   localparam logic [3:0] RATE_MAX = 4'hD;
   // divider start count; counts to MOD_LAST, so sixteen adc clock periods per modulator period
   localparam logic [3:0] MOD_DIV = 4'h0;
   localparam logic [3:0] MOD_LAST = 4'hF;
   localparam logic [CNT_W-1:0] DLY_BASE_MODS = 19'h0000E;
   localparam logic [1:0] SETTLE_LAST = 2'h2;
   // first-result time without delay, in modulator periods
   localparam logic [CNT_W-1:0] FIRST_MODS [RATE_N] = '{
      19'h4B041, 19'h25841, 19'h12C41, 19'h0B441, 19'h09641, 19'h03C41,
      19'h03239, 19'h01E41, 19'h00F41, 19'h007C1, 19'h00401, 19'h00328,
      19'h001A8, 19'h000E8};
   // nominal data period, in modulator periods
   localparam logic [CNT_W-1:0] PERIOD_MODS [RATE_N] = '{
      19'h19000, 19'h0C800, 19'h06400, 19'h03C00, 19'h03200, 19'h01400,
      19'h010A8, 19'h00A00, 19'h00500, 19'h00280, 19'h00140, 19'h00100,
      19'h00080, 19'h00040};
   // bits of growth per filter stage, rounded up
   localparam logic [5:0] GROW_BITS [RATE_N] = '{
      6'h11, 6'h10, 6'h0F, 6'h0E, 6'h0E, 6'h0D, 6'h0D, 6'h0C, 6'h0B,
      6'h0A, 6'h09, 6'h08, 6'h07, 6'h06};
   localparam logic [5:0] OUT_FRAC = 6'h0F;
   typedef enum logic [2:0] {
      SCF_IDLE = 3'b001,
      SCF_DELAY = 3'b010,
      SCF_SAMPLE = 3'b100
   } scf_state_e;
endpackage
`default_nettype wire

// file: rtl/scf_core.sv
/*
 Sinc-cubed decimation filter with conversion sequencing, a register port
 and a two-entry result buffer.
 Assumes adcTick pulses once per ADC clock in the core_clk domain, startCmd
 pulses on the seventh falling serial clock edge of a start command, and
 modBitPin and trigPin are asynchronous pins.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scf_core #(
   parameter int RES_W = 16
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic adcTick,
   input wire logic modBitPin,
   input wire logic trigPin,
   input wire logic startCmd,
   input wire logic stopCmd,
   input wire logic [scf_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic [RES_W-1:0] resData,
   output logic resValid,
   input wire logic resReady
);
   localparam int CW = scf_pkg::CNT_W;
   localparam int AW = scf_pkg::ACC_W;

   scf_pkg::scf_state_e state_q, state_d;
   logic modSync1_q, modSync2_q, trigSync1_q, trigSync2_q, trigPrev_q;
   logic [7:0] dataRate_q;
   logic [2:0] dlyCfg_q;
   logic [3:0] rateSel_q;
   logic sinc3_q, single_q;
   logic [3:0] divCnt_q;
   logic [CW-1:0] cnt_q, ovhCnt_q;
   logic [1:0] settle_q;
   logic ovhBusy_q;
   logic [1:0] decimNo_q;
   logic [CW-1:0] ovhAge_q;
   logic signed [AW-1:0] int1_q, int2_q, int3_q, dly1_q, dly2_q, dly3_q;
   logic signed [AW-1:0] ovhData_q;
   logic [RES_W-1:0] lastRes_q, skidData_q, resData_q;
   logic skidValid_q, resValid_q;
   logic [31:0] regRdata_q;

   wire stIdle = (state_q == scf_pkg::SCF_IDLE);
   wire stDelay = (state_q == scf_pkg::SCF_DELAY);
   wire stSample = (state_q == scf_pkg::SCF_SAMPLE);
   wire trigRise = trigSync2_q & ~trigPrev_q;
   wire startReq = trigRise | startCmd;
   wire filterBit = dataRate_q[scf_pkg::DR_FILTER_BIT];
   wire [3:0] rateField = dataRate_q[scf_pkg::DR_RATE_LSB +: 4];
   wire [3:0] rateNow = (rateField > scf_pkg::RATE_MAX) ?
      scf_pkg::RATE_MAX : rateField;
   wire [CW-1:0] periodMods = scf_pkg::PERIOD_MODS[rateSel_q];
   wire [CW-1:0] firstMods = scf_pkg::FIRST_MODS[rateSel_q];
   // overhead is what the first result needs beyond three data periods
   wire [CW-1:0] ovhMods = firstMods - CW'(3 * periodMods);
   wire [CW-1:0] dlyMods = scf_pkg::DLY_BASE_MODS << dlyCfg_q;
   wire [CW-1:0] cntTarget = stDelay ? dlyMods : periodMods;
   wire lastCnt = (cnt_q == cntTarget - CW'(1));
   wire inReady = ~skidValid_q;
   wire finish = ovhBusy_q & (ovhCnt_q == '0);
   wire push = finish & inReady;
   // a finished word with a full buffer freezes the conversion
   wire adv = clkEn & ~(finish & ~inReady);
   wire modTick = adcTick & ~stIdle &
      (divCnt_q == scf_pkg::MOD_LAST);
   wire decim = stSample & modTick & lastCnt;
   wire suppress = sinc3_q & (settle_q != scf_pkg::SETTLE_LAST);
   wire ovhLoad = decim & ~suppress;
   wire signed [AW-1:0] modSample = modSync2_q ? AW'(1) : -AW'(1);
   // comb taps the updated integrator so the third result is fully settled
   wire signed [AW-1:0] int3Next = int3_q + int2_q;
   wire signed [AW-1:0] comb1 = int3Next - dly1_q;
   wire signed [AW-1:0] comb2 = comb1 - dly2_q;
   wire signed [AW-1:0] comb3 = comb2 - dly3_q;
   wire [5:0] outShift = 6'(3 * scf_pkg::GROW_BITS[rateSel_q])
      - scf_pkg::OUT_FRAC;
   wire signed [AW-1:0] scaled = ovhData_q >>> outShift;
   wire [RES_W-1:0] resWord = scaled[RES_W-1:0];
   wire wrRate = regWr & (regAddr == scf_pkg::REG_DATARATE);
   wire wrDly = regWr & (regAddr == scf_pkg::REG_DELAY);
   wire [31:0] statusWord = {24'h0, ovhBusy_q, resValid_q, skidValid_q,
      settle_q, state_q};
   wire [31:0] rdMux =
      (regAddr == scf_pkg::REG_DATARATE) ? {24'h0, dataRate_q} :
      (regAddr == scf_pkg::REG_DELAY) ? {29'h0, dlyCfg_q} :
      (regAddr == scf_pkg::REG_STATUS) ? statusWord :
      (regAddr == scf_pkg::REG_RESULT) ? {{(32-RES_W){1'b0}}, lastRes_q} :
      32'h0;

   always_comb begin
      state_d = state_q;
      case (state_q)
         scf_pkg::SCF_IDLE: begin
            if (startReq) begin
               state_d = scf_pkg::SCF_DELAY;
            end
         end
         scf_pkg::SCF_DELAY: begin
            if (modTick && lastCnt) begin
               state_d = scf_pkg::SCF_SAMPLE;
            end
         end
         scf_pkg::SCF_SAMPLE: begin
            // continuous mode never goes back through the delay
            if (push && single_q) begin
               state_d = scf_pkg::SCF_IDLE;
            end
         end
         default: state_d = scf_pkg::SCF_IDLE;
      endcase
      if (stopCmd) begin
         state_d = scf_pkg::SCF_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         modSync1_q <= 1'b0;
         modSync2_q <= 1'b0;
         trigSync1_q <= 1'b0;
         trigSync2_q <= 1'b0;
         trigPrev_q <= 1'b0;
      end else if (clkEn) begin
         modSync1_q <= modBitPin;
         modSync2_q <= modSync1_q;
         trigSync1_q <= trigPin;
         trigSync2_q <= trigSync1_q;
         trigPrev_q <= trigSync2_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         dataRate_q <= scf_pkg::DATARATE_RST;
         dlyCfg_q <= scf_pkg::DELAY_RST;
         regRdata_q <= 32'h0;
      end else if (clkEn) begin
         if (wrRate) begin
            dataRate_q <= regWdata[7:0];
         end
         if (wrDly) begin
            dlyCfg_q <= regWdata[2:0];
         end
         regRdata_q <= regRd ? rdMux : 32'h0;
      end
   end

   // sequencing: same start, delay and sampling for both filters; only sinc-cubed suppresses two results
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_q <= scf_pkg::SCF_IDLE;
         rateSel_q <= scf_pkg::RATE_MAX;
         sinc3_q <= 1'b1;
         single_q <= 1'b0;
         divCnt_q <= scf_pkg::MOD_DIV;
         cnt_q <= '0;
         settle_q <= 2'h0;
      end else if (adv) begin
         state_q <= state_d;
         if (stIdle) begin
            rateSel_q <= rateNow;
            sinc3_q <= ~filterBit;
            single_q <= dataRate_q[scf_pkg::DR_SINGLE_BIT];
            settle_q <= 2'h0;
            cnt_q <= '0;
            divCnt_q <= scf_pkg::MOD_DIV;
         end else begin
            if (adcTick) begin
               divCnt_q <= divCnt_q + 4'h1;
            end
            if (modTick) begin
               cnt_q <= lastCnt ? '0 : cnt_q + CW'(1);
            end
            if (decim && suppress) begin
               settle_q <= settle_q + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn || (adv && stIdle)) begin
         int1_q <= '0;
         int2_q <= '0;
         int3_q <= '0;
         dly1_q <= '0;
         dly2_q <= '0;
         dly3_q <= '0;
      end else if (adv && stSample && modTick) begin
         int1_q <= int1_q + modSample;
         int2_q <= int2_q + int1_q;
         int3_q <= int3_q + int2_q;
         if (lastCnt) begin
            dly1_q <= int3Next;
            dly2_q <= comb1;
            dly3_q <= comb2;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn || (adv && stIdle)) begin
         ovhBusy_q <= 1'b0;
         ovhCnt_q <= '0;
         ovhData_q <= '0;
      end else if (clkEn) begin
         if (ovhLoad && adv) begin
            ovhBusy_q <= 1'b1;
            ovhCnt_q <= ovhMods;
            ovhData_q <= comb3;
         end else if (push) begin
            ovhBusy_q <= 1'b0;
         end else if (adv && modTick && ovhCnt_q != '0) begin
            ovhCnt_q <= ovhCnt_q - CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         resValid_q <= 1'b0;
         resData_q <= '0;
         skidValid_q <= 1'b0;
         skidData_q <= '0;
         lastRes_q <= '0;
      end else if (clkEn) begin
         if (push) begin
            lastRes_q <= resWord;
         end
         if (resValid_q && resReady) begin
            resValid_q <= skidValid_q | push;
            resData_q <= skidValid_q ? skidData_q : resWord;
            skidValid_q <= 1'b0;
         end else if (push && !resValid_q) begin
            resValid_q <= 1'b1;
            resData_q <= resWord;
         end else if (push) begin
            skidValid_q <= 1'b1;
            skidData_q <= resWord;
         end
      end
   end

   // assertion helpers: decimations since start (held at two), modulator periods since overhead load
   always_ff @(posedge core_clk) begin
      if (!resetn || (adv && stIdle)) begin
         decimNo_q <= 2'h0;
      end else if (adv && decim && decimNo_q != scf_pkg::SETTLE_LAST) begin
         decimNo_q <= decimNo_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn || (adv && ovhLoad)) begin
         ovhAge_q <= '0;
      end else if (adv && modTick && ovhBusy_q) begin
         ovhAge_q <= ovhAge_q + CW'(1);
      end
   end

   assign regRdata = regRdata_q;
   assign resData = resData_q;
   assign resValid = resValid_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_startIdle;
      clkEn && stIdle && startReq && !stopCmd && !finish;
   endsequence
   sequence s_singleDone;
      clkEn && push && single_q && !stopCmd;
   endsequence

   a_start_delay: assert property (
      s_startIdle |=> stDelay)
      else $error("start request did not open the delay");
   a_delay_exit: assert property (
      $rose(stSample) |-> $past(stDelay) && $past(lastCnt))
      else $error("sampling began before the delay ran out");
   a_no_redelay: assert property (
      stSample |=> !stDelay)
      else $error("later conversion repeated the delay");
   a_suppress_two: assert property (
      (ovhLoad && sinc3_q) |-> decimNo_q == scf_pkg::SETTLE_LAST)
      else $error("unsettled result went on to output");
   a_no_ovh_supp: assert property (
      (clkEn && decim && sinc3_q && settle_q < 2'h2) |=> !ovhBusy_q)
      else $error("suppressed result was given overhead time");
   a_ovh_push: assert property (
      push |-> ovhBusy_q && ovhAge_q == ovhMods)
      else $error("result delivered before overhead elapsed");
   a_single_stop: assert property (
      s_singleDone |=> stIdle ##1 (stIdle || $past(startReq)))
      else $error("single-shot kept converting");
   a_filter_pick: assert property (
      $rose(stDelay) |-> sinc3_q == !$past(filterBit))
      else $error("filter choice not taken from the filter bit");
   a_skid_hold: assert property (
      (resValid_q && !resReady) |=> resValid_q && $stable(resData_q))
      else $error("buffered result dropped under stall");
endmodule
`default_nettype wire

// file: test/scf_sink.sv
/*
 Consumer model for the result stream of the sinc-cubed filter.
 Assumes the core_clk domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module scf_sink (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic stall,
   output logic resReady
);
   // ready is registered, so a stall shows one cycle late like a real sink
   always @(posedge core_clk) begin
      if (!resetn) begin
         resReady <= 1'b0;
      end else begin
         resReady <= !stall;
      end
   end
endmodule
`default_nettype wire

// file: test/sinc3_filter_conversion_timing_test.sv
/*
 Self-checking bench for scf_core with a consumer model on the results.
 Holds adcTick high every cycle except in the clock scale test, so a modulator period is 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sinc3_filter_conversion_timing_test;
   localparam int MP = 16;
   logic core_clk = 1'b0, resetn = 1'b0, modBitPin = 1'b1, trigPin = 1'b0;
   logic startCmd = 1'b0, stopCmd = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic stall = 1'b0, rnd = 1'b0, resValid, resReady;
   logic adcTick = 1'b1, half = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0, regRdata, v;
   logic [15:0] resData, d, ew;
   int cyc = 0, err_count = 0, num_checks = 0, t0, t, ta, tp;
   int dm = int'(scf_pkg::DLY_BASE_MODS);
   int fm = int'(scf_pkg::FIRST_MODS[13]);
   int pm = int'(scf_pkg::PERIOD_MODS[13]);

   scf_core u_dut (.core_clk, .resetn, .clkEn(1'b1), .adcTick,
      .modBitPin, .trigPin, .startCmd, .stopCmd, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .resData, .resValid, .resReady);
   scf_sink u_sink (.core_clk, .resetn, .stall, .resReady);

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      adcTick <= half ? ~adcTick : 1'b1;
      if (rnd) begin
         modBitPin <= 1'($urandom);
      end
      if (cyc == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   task check(string n, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task wr(logic [7:0] a, logic [31:0] w);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= w;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task rd(logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask

   task start();
      @(posedge core_clk);
      startCmd <= 1'b1;
      t0 = cyc;
      @(posedge core_clk);
      startCmd <= 1'b0;
   endtask

   // stamps the cycle at which the consumer takes a word
   task await_word();
      t = -1;
      repeat (8000) begin
         @(posedge core_clk);
         if (resValid === 1'b1 && resReady === 1'b1) begin
            t = cyc;
            d = resData;
            break;
         end
      end
      check("word arrival", t >= 0, 1);
   endtask

   task give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(32'hD37C));
      ew = 16'((pm ** 3) >>> (3 * $clog2(pm) - 15));
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      rd(scf_pkg::REG_DATARATE);
      check("datarate reset", v, 32'(scf_pkg::DATARATE_RST));
      rd(scf_pkg::REG_DELAY);
      check("delay reset", v, 32'h0);
      wr(scf_pkg::REG_STATUS, 32'hFF);
      rd(scf_pkg::REG_STATUS);
      check("status idle", v[2:0], 3'b001);
      rd(8'h20);
      check("unmapped read", v, 32'h0);
      $display("register test done");
      wr(scf_pkg::REG_DATARATE, 32'h2D);
      rd(scf_pkg::REG_DATARATE);
      check("datarate write", v, 32'h2D);
      start();
      await_word();
      ta = t - t0;
      check("first time", ta >= (dm + fm) * MP && ta <= (dm + fm) * MP + 24,
         1);
      check("settled word", d, ew);
      repeat (3000) @(posedge core_clk);
      check("single stop", resValid, 1'b0);
      rd(scf_pkg::REG_STATUS);
      check("single idle", v[2:0], 3'b001);
      rd(scf_pkg::REG_RESULT);
      check("result reg", v, 32'(ew));
      $display("single-shot test done");
      wr(scf_pkg::REG_DELAY, 32'h1);
      start();
      await_word();
      check("delay step", t - t0 - ta, dm * MP);
      $display("delay test done");
      wr(scf_pkg::REG_DELAY, 32'h0);
      half = 1'b1;
      start();
      await_word();
      check("tick scaling", t - t0 >= 2 * ta - 8 && t - t0 <= 2 * ta + 8,
         1);
      half = 1'b0;
      $display("clock scale test done");
      wr(scf_pkg::REG_DATARATE, 32'h3F);
      rnd = 1'b1;
      start();
      await_word();
      check("suppressed two", ta - (t - t0), 2 * pm * MP);
      rnd = 1'b0;
      modBitPin <= 1'b1;
      $display("filter select test done");
      wr(scf_pkg::REG_DATARATE, 32'h0D);
      wr(scf_pkg::REG_DELAY, 32'h1);
      @(posedge core_clk);
      trigPin <= 1'b1;
      t0 = cyc;
      await_word();
      check("trigger first", t - t0 >= (2 * dm + fm) * MP &&
         t - t0 <= (2 * dm + fm) * MP + 24, 1);
      tp = t;
      trigPin <= 1'b0;
      await_word();
      check("period", t - tp, pm * MP);
      check("continuous word", d, ew);
      stall <= 1'b1;
      repeat (2600) @(posedge core_clk);
      rd(scf_pkg::REG_STATUS);
      check("buffer full", v[6:5], 2'b11);
      stall <= 1'b0;
      await_word();
      tp = t;
      check("held word", d, ew);
      await_word();
      check("drain back to back", t - tp, 1);
      check("second held word", d, ew);
      @(posedge core_clk);
      stopCmd <= 1'b1;
      @(posedge core_clk);
      stopCmd <= 1'b0;
      rd(scf_pkg::REG_STATUS);
      check("stopped idle", v[2:0], 3'b001);
      $display("continuous test done");
      give_verdict();
   end
endmodule
`default_nettype wire
